// file: src/dds_pkg.sv
// shared types and constants for the dual data space access unit
package dds_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;
  // default x/y boundary: first word address of the y space
  localparam logic [ADDR_W-1:0] Y_BASE_DEF = 16'h8000;
  // read latency of the data ram, in cycles after the strobe
  localparam int RAM_RD_LAT = 1;

  // instruction class as seen by the operand fetch logic
  typedef enum logic [3:0] {
    op_mcu                 = 4'h0,
    accumulator_clear_op   = 4'h1,
    distance_op            = 4'h2,
    distance_accumulate_op = 4'h3,
    multiply_accumulate_op = 4'h4,
    accumulate_move_op     = 4'h5,
    multiply_op            = 4'h6,
    negated_multiply_op    = 4'h7,
    multiply_subtract_op   = 4'h8
  } op_e;

  // address update mode asked of an address generator
  typedef enum logic [1:0] {
    am_linear = 2'h0,
    am_modulo = 2'h1,
    am_bitrev = 2'h2
  } mode_e;

  // one address generator request from the core
  typedef struct packed {
    logic              valid;
    logic              write;
    mode_e             mode;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] incr;
    logic [DATA_W-1:0] wdata;
  } agen_req_s;

  // circular buffer bounds, inclusive
  typedef struct packed {
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } mod_cfg_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
  } rd_port_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_port_s;

  // which ram port carries each operand
  typedef struct packed {
    logic x_vld;
    logic x_on_y;
    logic y_vld;
    logic y_on_x;
  } tag_s;

  typedef struct packed {
    logic mode;
    logic route;
  } fault_s;

endpackage : dds_pkg

// file: src/dual_data_space_access.sv
// dual data space access unit: x/y address generation and ram port steering
`timescale 1ns/1ps

// Functional notes
// [RQ1] data memory is split into x and y spaces, each with its own address generator and path.
// [RQ2] ordinary ops see one linear range while mac class ops treat x and y as separate regions.
// [RQ3] the x space serves every instruction class and every addressing mode.
// [RQ4] the x side has a read bus and a write bus that are separate paths.
// [RQ5] the x read bus carries all combined-space reads and the x operand of dual reads; here an x operand at or above Y_BASE, y below, rides the y port.
// [RQ6] the y space is used only alongside x by the mac class ops for a second read path.
// [RQ7] both address generators offer circular addressing for all instructions; here the y generator only updates for mac class ops.
// [RQ8] bit-reversed update applies to x writes only, never to reads or to y.
// [RQ9] with the dsp option off neither circular nor bit-reversed update exists.
// [RQ10] every write is decoded against the combined x plus y space.
// [RQ11] the x/y boundary is fixed per build and cannot be moved at run time.
// [RQ12] the boundary is a parameter and dual reads are steered to x or y port by it.
module dual_data_space_access #(
  parameter logic                      DSP_EN = 1'b1,
  parameter logic [dds_pkg::ADDR_W-1:0] Y_BASE = dds_pkg::Y_BASE_DEF
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // core request side
  input  wire dds_pkg::op_e               i_op,
  input  wire dds_pkg::agen_req_s         i_x_req,
  input  wire dds_pkg::agen_req_s         i_y_req,
  input  wire dds_pkg::mod_cfg_s          i_x_mod,
  input  wire dds_pkg::mod_cfg_s          i_y_mod,
  // ram read data
  input  wire logic [dds_pkg::DATA_W-1:0] i_x_rdata,
  input  wire logic [dds_pkg::DATA_W-1:0] i_y_rdata,
  // ram ports
  output dds_pkg::rd_port_s               o_x_rd,
  output dds_pkg::rd_port_s               o_y_rd,
  output dds_pkg::wr_port_s               o_wr,
  // core answer side
  output logic [dds_pkg::ADDR_W-1:0]      o_x_next,
  output logic [dds_pkg::ADDR_W-1:0]      o_y_next,
  output logic                            o_x_opnd_vld,
  output logic [dds_pkg::DATA_W-1:0]      o_x_opnd,
  output logic                            o_y_opnd_vld,
  output logic [dds_pkg::DATA_W-1:0]      o_y_opnd,
  output dds_pkg::fault_s                 o_fault
);

  typedef struct packed {
    dds_pkg::rd_port_s                        x_rd;
    dds_pkg::rd_port_s                        y_rd;
    dds_pkg::wr_port_s                        wr;
    logic [dds_pkg::ADDR_W-1:0]               x_next;
    logic [dds_pkg::ADDR_W-1:0]               y_next;
    dds_pkg::tag_s [dds_pkg::RAM_RD_LAT:0]    tag;
    logic                                     x_vld;
    logic [dds_pkg::DATA_W-1:0]               x_opnd;
    logic                                     y_vld;
    logic [dds_pkg::DATA_W-1:0]               y_opnd;
    dds_pkg::fault_s                          fault;
  } state_s;

  localparam state_s STATE_RST = '{
    x_rd:   '{en: 1'b0, addr: dds_pkg::ADDR_RST},
    y_rd:   '{en: 1'b0, addr: dds_pkg::ADDR_RST},
    wr:     '{en: 1'b0, addr: dds_pkg::ADDR_RST, data: dds_pkg::DATA_RST},
    x_next: dds_pkg::ADDR_RST,
    y_next: dds_pkg::ADDR_RST,
    tag:    '0,
    x_vld:  1'b0,
    x_opnd: dds_pkg::DATA_RST,
    y_vld:  1'b0,
    y_opnd: dds_pkg::DATA_RST,
    fault:  '0
  };

  // reverse the bit order of an address
  function automatic logic [dds_pkg::ADDR_W-1:0] rev(input logic [dds_pkg::ADDR_W-1:0] a);
    logic [dds_pkg::ADDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < dds_pkg::ADDR_W; i++) begin
      r[i] = a[dds_pkg::ADDR_W-1-i];
    end
    return r;
  endfunction : rev

  // boundary compare; Y_BASE is a parameter so nothing at run time can move it
  function automatic logic in_y(input logic [dds_pkg::ADDR_W-1:0] a);
    return a >= Y_BASE; // [RQ11] [RQ12]
  endfunction : in_y

  // post-update address of one generator
  function automatic logic [dds_pkg::ADDR_W-1:0] agen_next(
    input dds_pkg::agen_req_s r,
    input dds_pkg::mod_cfg_s  m,
    input logic               brev_ok
  );
    logic                       down;
    logic [dds_pkg::ADDR_W-1:0] lin;
    down = r.incr[dds_pkg::ADDR_W-1];
    lin  = r.addr + r.incr;
    agen_next = lin;
    if (DSP_EN) begin // [RQ9]
      if (r.mode == dds_pkg::am_modulo) begin // [RQ7]
        if (!down && r.addr == m.hi) begin
          agen_next = m.lo;
        end else if (down && r.addr == m.lo) begin
          agen_next = m.hi;
        end
      end else if (r.mode == dds_pkg::am_bitrev && brev_ok) begin // [RQ8]
        // reverse-carry add walks fft butterflies in place
        agen_next = rev(rev(r.addr) + rev(r.incr));
      end
    end
  endfunction : agen_next

  // release reset through two flops
  logic [1:0] rst_sync_q;
  logic       rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  state_s s_q;
  state_s s_d;

  logic is_mac;
  logic dual;
  logic x_sel_y;
  logic y_sel_y;
  logic x_brev_ok;
  logic clash;
  logic bad_mode;

  // request decode
  always_comb begin
    is_mac    = (i_op != dds_pkg::op_mcu); // [RQ2] [RQ6]
    dual      = is_mac && i_x_req.valid && !i_x_req.write && i_y_req.valid; // [RQ1]
    x_sel_y   = in_y(i_x_req.addr);
    y_sel_y   = in_y(i_y_req.addr);
    clash     = dual && (x_sel_y == y_sel_y);
    x_brev_ok = i_x_req.write; // [RQ8]
    bad_mode  = (i_x_req.valid && i_x_req.mode == dds_pkg::am_bitrev && !x_brev_ok)
              || (i_y_req.valid && i_y_req.mode == dds_pkg::am_bitrev)
              || (!DSP_EN && i_x_req.valid && i_x_req.mode != dds_pkg::am_linear)
              || (!DSP_EN && i_y_req.valid && i_y_req.mode != dds_pkg::am_linear);
  end

  // next state of the whole unit
  always_comb begin
    s_d          = s_q;
    s_d.x_rd.en  = 1'b0;
    s_d.y_rd.en  = 1'b0;
    s_d.wr.en    = 1'b0;
    s_d.tag[0]   = '0;
    s_d.x_vld    = 1'b0;
    s_d.y_vld    = 1'b0;
    s_d.fault    = '0;

    // x generator runs for any valid request, y generator only for a valid mac class request
    if (i_x_req.valid) begin
      s_d.x_next = agen_next(i_x_req, i_x_mod, x_brev_ok); // [RQ3] [RQ7]
    end
    if (i_y_req.valid && is_mac) begin
      s_d.y_next = agen_next(i_y_req, i_y_mod, 1'b0); // [RQ7] [RQ8]
    end

    // writes always take the combined space on the x write bus
    if (i_x_req.valid && i_x_req.write) begin
      s_d.wr.en   = 1'b1; // [RQ4] [RQ10]
      s_d.wr.addr = i_x_req.addr;
      s_d.wr.data = i_x_req.wdata;
    end

    if (dual && !clash) begin
      // each operand goes to the port that owns its address
      if (x_sel_y) begin
        s_d.y_rd.en       = 1'b1; // [RQ12]
        s_d.y_rd.addr     = i_x_req.addr;
        s_d.x_rd.en       = 1'b1;
        s_d.x_rd.addr     = i_y_req.addr;
        s_d.tag[0].x_on_y = 1'b1;
        s_d.tag[0].y_on_x = 1'b1;
      end else begin
        s_d.x_rd.en   = 1'b1; // [RQ5] [RQ12]
        s_d.x_rd.addr = i_x_req.addr;
        s_d.y_rd.en   = 1'b1; // [RQ6]
        s_d.y_rd.addr = i_y_req.addr;
      end
      s_d.tag[0].x_vld = 1'b1;
      s_d.tag[0].y_vld = 1'b1;
    end else if (i_x_req.valid && !i_x_req.write) begin
      // combined-space read, or the x half of a clashing pair
      s_d.x_rd.en      = 1'b1; // [RQ5]
      s_d.x_rd.addr    = i_x_req.addr;
      s_d.tag[0].x_vld = 1'b1;
    end

    // y read outside the mac class, a mac y read with no x access beside it, or a pair that both sit in one space
    s_d.fault.route = clash || (i_y_req.valid && !is_mac)
                    || (is_mac && i_y_req.valid && !dual && !i_x_req.write);
    s_d.fault.mode  = bad_mode; // [RQ8] [RQ9]

    // age the port tags to line up with ram latency
    for (int i = 1; i <= dds_pkg::RAM_RD_LAT; i++) begin
      s_d.tag[i] = s_q.tag[i-1];
    end

    // capture returned words onto the operand they belong to
    if (s_q.tag[dds_pkg::RAM_RD_LAT].x_vld) begin
      s_d.x_vld  = 1'b1;
      s_d.x_opnd = s_q.tag[dds_pkg::RAM_RD_LAT].x_on_y ? i_y_rdata : i_x_rdata;
    end
    if (s_q.tag[dds_pkg::RAM_RD_LAT].y_vld) begin
      s_d.y_vld  = 1'b1;
      s_d.y_opnd = s_q.tag[dds_pkg::RAM_RD_LAT].y_on_x ? i_x_rdata : i_y_rdata;
    end
  end

  // single state register
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign o_x_rd       = s_q.x_rd;
  assign o_y_rd       = s_q.y_rd;
  assign o_wr         = s_q.wr;
  assign o_x_next     = s_q.x_next;
  assign o_y_next     = s_q.y_next;
  assign o_x_opnd_vld = s_q.x_vld;
  assign o_x_opnd     = s_q.x_opnd;
  assign o_y_opnd_vld = s_q.y_vld;
  assign o_y_opnd     = s_q.y_opnd;
  assign o_fault      = s_q.fault;

endmodule : dual_data_space_access

// file: testbench/dds_monitor.sv
// assertion checker bound to the dual data space access unit
`timescale 1ns/1ps
module dds_monitor #(
  parameter logic                       DSP_EN = 1'b1,
  parameter logic [dds_pkg::ADDR_W-1:0] Y_BASE = dds_pkg::Y_BASE_DEF
) (
  // watched ports
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  input wire dds_pkg::op_e       i_op,
  input wire dds_pkg::agen_req_s i_x_req,
  input wire dds_pkg::agen_req_s i_y_req,
  input wire dds_pkg::mod_cfg_s  i_x_mod,
  input wire dds_pkg::rd_port_s  o_x_rd,
  input wire dds_pkg::rd_port_s  o_y_rd,
  input wire dds_pkg::wr_port_s  o_wr,
  input wire logic [15:0]        o_x_next,
  input wire logic               o_x_opnd_vld,
  input wire logic               o_y_opnd_vld,
  input wire dds_pkg::fault_s    o_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // request classification shared by the properties
  wire logic mac_op = i_op != dds_pkg::op_mcu;
  wire logic x_read = i_x_req.valid && !i_x_req.write;
  wire logic dual   = mac_op && x_read && i_y_req.valid;
  wire logic x_hi   = i_x_req.addr >= Y_BASE;
  wire logic y_hi   = i_y_req.addr >= Y_BASE;

  a_mcu_x_read: assert property (!mac_op && x_read |=> o_x_rd.en && o_x_rd.addr == $past(i_x_req.addr))
    else $error("combined read left the x port");
  a_write_comb: assert property (i_x_req.valid && i_x_req.write |=> o_wr.en && o_wr.addr == $past(i_x_req.addr) && o_wr.data == $past(i_x_req.wdata))
    else $error("write not issued on combined space");
  a_y_mcu_drop: assert property (!mac_op && i_y_req.valid |=> o_fault.route && !o_y_rd.en)
    else $error("y read outside mac class");
  a_split_ports: assert property (dual && !x_hi && y_hi |=> o_x_rd.en && o_y_rd.en && o_y_rd.addr == $past(i_y_req.addr))
    else $error("dual read not split over both ports");
  a_swap_route: assert property (dual && x_hi && !y_hi |=> o_y_rd.addr == $past(i_x_req.addr) && o_x_rd.addr == $past(i_y_req.addr))
    else $error("dual read not steered by boundary");
  a_dual_opnds: assert property (dual && (x_hi != y_hi) |=> ##2 o_x_opnd_vld && o_y_opnd_vld)
    else $error("dual operands not both delivered");
  a_brev_read: assert property ((x_read && i_x_req.mode == dds_pkg::am_bitrev) || (i_y_req.valid && i_y_req.mode == dds_pkg::am_bitrev) |=> o_fault.mode)
    else $error("bit-reversed read not refused");
  a_mod_wrap: assert property (DSP_EN && i_x_req.valid && i_x_req.mode == dds_pkg::am_modulo && i_x_req.addr == i_x_mod.hi && !i_x_req.incr[15] && i_x_req.incr != 16'h0000 |=> o_x_next == $past(i_x_mod.lo))
    else $error("circular wrap at upper bound wrong");
  a_lite_fault: assert property (!DSP_EN && i_x_req.valid && i_x_req.mode != dds_pkg::am_linear |=> o_fault.mode)
    else $error("reduced build accepted a dsp mode");
endmodule : dds_monitor

bind dual_data_space_access dds_monitor #(.DSP_EN(DSP_EN), .Y_BASE(Y_BASE)) u_mon (.i_clk, .i_rst_b,
  .i_op, .i_x_req, .i_y_req, .i_x_mod, .o_x_rd, .o_y_rd, .o_wr, .o_x_next, .o_x_opnd_vld,
  .o_y_opnd_vld, .o_fault);

// file: testbench/dds_ram_model.sv
// data ram stand-in answering the x and y read strobes
`timescale 1ns/1ps
module dds_ram_model (
  // ram side of the unit
  input  wire logic              i_clk,
  input  wire dds_pkg::rd_port_s i_x_rd,
  input  wire dds_pkg::rd_port_s i_y_rd,
  output logic [15:0]            o_x_rdata,
  output logic [15:0]            o_y_rdata
);
  // answer one cycle after the strobe; idle cycles toggle so data one cycle stale never matches
  always_ff @(posedge i_clk) begin
    o_x_rdata <= i_x_rd.en ? i_x_rd.addr ^ 16'hA5A5 : ~o_x_rdata;
    o_y_rdata <= i_y_rd.en ? i_y_rd.addr ^ 16'h5A5A : ~o_y_rdata;
  end
endmodule : dds_ram_model

// file: testbench/dual_data_space_access_tb.sv
// self-checking bench for the dual data space access unit
`timescale 1ns/1ps
module dual_data_space_access_tb;
  logic               i_clk;
  logic               i_rst_b;
  dds_pkg::op_e       op;
  dds_pkg::agen_req_s xq, yq;
  dds_pkg::mod_cfg_s  xm;
  dds_pkg::rd_port_s  x_rd, y_rd;
  dds_pkg::wr_port_s  wr;
  dds_pkg::fault_s    flt;
  logic [15:0]        xrd_d, yrd_d, x_next, y_next, x_opnd, y_opnd;
  logic               xv, yv;
  int                 n_errors, n_compared;

  dual_data_space_access dut (.i_clk, .i_rst_b, .i_op(op), .i_x_req(xq), .i_y_req(yq),
    .i_x_mod(xm), .i_y_mod(xm), .i_x_rdata(xrd_d), .i_y_rdata(yrd_d), .o_x_rd(x_rd),
    .o_y_rd(y_rd), .o_wr(wr), .o_x_next(x_next), .o_y_next(y_next), .o_x_opnd_vld(xv),
    .o_x_opnd(x_opnd), .o_y_opnd_vld(yv), .o_y_opnd(y_opnd), .o_fault(flt));
  // reduced build sees the same traffic; only its bound checker judges it
  dual_data_space_access #(.DSP_EN(1'b0)) dut_lite (.i_clk, .i_rst_b, .i_op(op),
    .i_x_req(xq), .i_y_req(yq), .i_x_mod(xm), .i_y_mod(xm), .i_x_rdata(xrd_d),
    .i_y_rdata(yrd_d), .o_x_rd(), .o_y_rd(), .o_wr(), .o_x_next(), .o_y_next(),
    .o_x_opnd_vld(), .o_x_opnd(), .o_y_opnd_vld(), .o_y_opnd(), .o_fault());
  dds_ram_model ram (.i_clk, .i_x_rd(x_rd), .i_y_rd(y_rd), .o_x_rdata(xrd_d), .o_y_rdata(yrd_d));

  // free-running core clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic cmp_w(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_w

  task automatic cmp_f(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask : cmp_f

  function automatic dds_pkg::agen_req_s rq(logic w, dds_pkg::mode_e m, logic [15:0] a,
                                            logic [15:0] i);
    return '{1'b1, w, m, a, i, 16'h3C3C};
  endfunction : rq

  // one-cycle request; returns just after the answer edge has settled
  task automatic issue(input dds_pkg::op_e o, input dds_pkg::agen_req_s x,
                       input dds_pkg::agen_req_s y);
    @(posedge i_clk);
    op <= o;
    xq <= x;
    yq <= y;
    @(posedge i_clk);
    xq.valid <= 1'b0;
    yq.valid <= 1'b0;
    #1;
  endtask : issue

  // operands land two edges after the strobe edge
  task automatic wait_opnd;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : wait_opnd

  task automatic t_mcu_read;
    issue(dds_pkg::op_mcu, rq(1'b0, dds_pkg::am_linear, 16'h9000, 16'h0002),
          rq(1'b0, dds_pkg::am_linear, 16'h8004, 16'h0002));
    cmp_w("x_rd.addr", 16'h9000, {16{x_rd.en}} & x_rd.addr);
    cmp_f("y_rd.en", 1'b0, y_rd.en);
    cmp_f("fault.route", 1'b1, flt.route);
    cmp_w("x_next", 16'h9002, x_next);
    wait_opnd;
    cmp_w("x_opnd", 16'h9000 ^ 16'hA5A5, {16{xv}} & x_opnd);
  endtask : t_mcu_read

  task automatic t_dual;
    for (int k = 1; k <= 8; k++) begin
      issue(dds_pkg::op_e'(k), rq(1'b0, dds_pkg::am_linear, 16'h0010, 16'h0001),
            rq(1'b0, dds_pkg::am_linear, 16'h8004, 16'h0002));
      cmp_w("y_rd.addr", 16'h8004, {16{y_rd.en}} & y_rd.addr);
      cmp_w("y_next", 16'h8006, y_next);
      wait_opnd;
      cmp_w("x_opnd", 16'h0010 ^ 16'hA5A5, {16{xv}} & x_opnd);
      cmp_w("y_opnd", 16'h8004 ^ 16'h5A5A, {16{yv}} & y_opnd);
    end
  endtask : t_dual

  task automatic t_swap_clash;
    issue(dds_pkg::multiply_op, rq(1'b0, dds_pkg::am_linear, 16'h8100, 16'h0001),
          rq(1'b0, dds_pkg::am_linear, 16'h0200, 16'h0001));
    wait_opnd;
    cmp_w("x_opnd", 16'h8100 ^ 16'h5A5A, x_opnd);
    cmp_w("y_opnd", 16'h0200 ^ 16'hA5A5, y_opnd);
    issue(dds_pkg::multiply_op, rq(1'b0, dds_pkg::am_linear, 16'h0020, 16'h0001),
          rq(1'b0, dds_pkg::am_linear, 16'h0030, 16'h0001));
    cmp_f("fault.route", 1'b1, flt.route);
    wait_opnd;
    cmp_f("y_vld", 1'b0, yv);
  endtask : t_swap_clash

  task automatic t_write_modes;
    issue(dds_pkg::multiply_op, rq(1'b1, dds_pkg::am_linear, 16'h8002, 16'h0002),
          rq(1'b0, dds_pkg::am_linear, 16'h8010, 16'h0002));
    cmp_w("wr.addr", 16'h8002, {16{wr.en}} & wr.addr);
    cmp_w("wr.data", 16'h3C3C, wr.data);
    cmp_f("x_rd.en", 1'b0, x_rd.en | y_rd.en);
    // 4000 + 8000 in reversed-carry order lands on C000
    issue(dds_pkg::op_mcu, rq(1'b1, dds_pkg::am_bitrev, 16'h4000, 16'h8000), '0);
    cmp_w("x_next", 16'hC000, x_next);
    cmp_f("fault.mode", 1'b0, flt.mode);
    issue(dds_pkg::op_mcu, rq(1'b0, dds_pkg::am_bitrev, 16'h0100, 16'h0004), '0);
    cmp_f("fault.mode", 1'b1, flt.mode);
    cmp_w("x_next", 16'h0104, x_next);
    // y asks for bit-reversed update: refused, falls back to linear
    issue(dds_pkg::multiply_op, rq(1'b0, dds_pkg::am_linear, 16'h0010, 16'h0001),
          rq(1'b0, dds_pkg::am_bitrev, 16'h8000, 16'h0004));
    cmp_f("fault.mode", 1'b1, flt.mode);
    cmp_w("y_next", 16'h8004, y_next);
  endtask : t_write_modes

  task automatic t_modulo;
    logic [15:0] a [3] = '{16'h010F, 16'h0100, 16'h0105};
    logic [15:0] i [3] = '{16'h0001, 16'hFFFF, 16'h0001};
    logic [15:0] e [3] = '{16'h0100, 16'h010F, 16'h0106};
    for (int k = 0; k < 3; k++) begin
      issue(dds_pkg::distance_op, rq(1'b0, dds_pkg::am_modulo, a[k], i[k]), '0);
      cmp_w("x_next", e[k], x_next);
    end
  endtask : t_modulo

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence: reset, then each scenario in turn
  initial begin
    n_errors = 0;
    n_compared = 0;
    i_rst_b = 1'b0;
    op = dds_pkg::op_mcu;
    xq = '0;
    yq = '0;
    xm = '{16'h0100, 16'h010F};
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_mcu_read;
    t_dual;
    t_swap_clash;
    t_write_modes;
    t_modulo;
    tally_and_finish;
  end

  // run needs well under 200 cycles; a hang is cut off far beyond that
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
endmodule : dual_data_space_access_tb
